// ---- verilog/lfcc_pkg.sv ----
// Constants, register map and carrier types for the low-frequency clock
// controller. Assumes a 100 MHz APB clock and 32-bit aligned registers.
package lfcc_pkg;

	// Clock rates and the derived low-frequency period in pclk cycles
	localparam int unsigned CLK_HZ         = 100_000_000; // APB clock
	localparam int unsigned LF_HZ          = 32_768;      // Slow clock
	localparam int unsigned LF_TICK_CYCLES = CLK_HZ / LF_HZ;

	// Register byte offsets
	localparam logic [11:0] OFS_HF_START   = 12'h000;
	localparam logic [11:0] OFS_HF_STOP    = 12'h004;
	localparam logic [11:0] OFS_LF_START   = 12'h008;
	localparam logic [11:0] OFS_LF_STOP    = 12'h00C;
	localparam logic [11:0] OFS_CAL        = 12'h010;
	localparam logic [11:0] OFS_CT_START   = 12'h014;
	localparam logic [11:0] OFS_CT_STOP    = 12'h018;
	localparam logic [11:0] OFS_EV_HF      = 12'h100;
	localparam logic [11:0] OFS_EV_LF      = 12'h104;
	localparam logic [11:0] OFS_EV_DONE    = 12'h10C;
	localparam logic [11:0] OFS_EV_TRIM_TIMER_EXPIRED_EVENT    = 12'h110;
	localparam logic [11:0] OFS_IRQ_SET    = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLR    = 12'h308;
	localparam logic [11:0] OFS_HF_REQ     = 12'h408;
	localparam logic [11:0] OFS_HF_STAT    = 12'h40C;
	localparam logic [11:0] OFS_LF_REQ     = 12'h414;
	localparam logic [11:0] OFS_LF_STAT    = 12'h418;
	localparam logic [11:0] OFS_LF_SNAP    = 12'h41C;
	localparam logic [11:0] OFS_LF_SRC     = 12'h518;
	localparam logic [11:0] OFS_CT_IV      = 12'h538;

	// Event indices, shared by event flags and interrupt enable bits
	localparam int EV_HF   = 0;
	localparam int EV_LF   = 1;
	localparam int EV_DONE = 3;
	localparam int EV_TRIM_TIMER_EXPIRED_EVENT = 4;
	localparam int EV_N    = 5;

	// Field positions
	localparam int SRC_LSB      = 0;  // Source field, two bits
	localparam int BYPASS_BIT   = 16; // Rail-to-rail bypass
	localparam int EXTERNAL_BIT = 17; // External clock on crystal pin one
	localparam int STATE_BIT    = 16; // Running flag in status registers

	// Source encodings
	localparam logic [1:0] SRC_RC    = 2'h0;
	localparam logic [1:0] SRC_XTAL  = 2'h1;
	localparam logic [1:0] SRC_SYNTH = 2'h2;

	// Synchroniser depth and reset values
	localparam int          SYNC_STAGES = 3;
	localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

	// Source selection carrier
	typedef struct packed {
		logic       external;
		logic       bypass;
		logic [1:0] src;
	} lfcc_src_t;

	localparam lfcc_src_t SRC_RESET = '{external: 1'b0, bypass: 1'b0,
		src: SRC_RC};

	// Slow clock controller states
	typedef enum logic [1:0] {
		LF_OFF,
		LF_STARTING,
		LF_RC_BRIDGE,
		LF_RUNNING
	} lfcc_lf_state_t;

endpackage : lfcc_pkg

// ---- verilog/lfcc_lowfreq_clock_control.sv ----
// Low-frequency clock controller: source select, start and stop, RC trim
// and the trim timer, all behind an APB slave.
// Assumes oscillator ready levels and the power-off level arrive
// asynchronously from analog cells; everything else runs on pclk.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Offer RC, crystal and synthesized sources.
// - Crystal start bridges on RC, then switches.
// - Started event once crystal runs.
// - Stop task stops the slow clock.
// - Power-off forces everything slow off.
// - Source defaults to RC after reset.
// - Trim task uses fast clock as reference.
// - Trim-done event when trimming ends.
// - Timer start and stop tasks.
// - Timer counts down, expires at zero, halts.
// - Source encodings and forbidden bit combinations.
// - External low-swing clock on pin one.
// - Rail-to-rail clock with bypass set.
// - Synthesized source keeps fast clock requested.
// - Start task snapshots the source selection.
// - Start-requested status separate from state.
// - Fast crystal start task and started event.
module lfcc_lowfreq_clock_control
	import lfcc_pkg::*;
#(
	parameter int CT_WIDTH  = 7,  // Trim timer interval width
	parameter int CAL_TICKS = 16  // Slow periods spent per trim run
) (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output var  logic [31:0]         prdata,
	output var  logic                pready,
	output var  logic                pslverr,
	// Analog status, asynchronous
	input  wire logic                rc_ready,
	input  wire logic                slow_xtal_ready,
	input  wire logic                fast_xtal_ready,
	input  wire logic                system_off,
	// Oscillator controls
	output var  logic                rc_enable,
	output var  logic                slow_xtal_enable,
	output var  logic                xtal_external,
	output var  logic                xtal_bypass,
	output var  logic                fast_xtal_enable,
	output var  logic                highfreq_request,
	output var  logic [1:0]          lowfreq_active_src,
	output var  logic                lowfreq_tick,
	// Interrupt
	output var  logic                irq
);

	// Parameter checks
	if (CT_WIDTH < 1 || CT_WIDTH > 32) begin : g_bad_ct
		$error("CT_WIDTH must lie in 1..32");
	end
	if (CAL_TICKS < 1 || CAL_TICKS > 255) begin : g_bad_cal
		$error("CAL_TICKS must lie in 1..255");
	end

	localparam int TICKW = $clog2(LF_TICK_CYCLES + 1);

	// Synchroniser chains; only stage two reads stage one
	logic [3:0]             pin_raw;
	logic [3:0]             sync_s1;
	logic [3:0]             sync_s2;
	logic [3:0]             sync_s3;
	logic [3:0]             pin_ok;      // Filtered levels
	assign pin_raw = {system_off, fast_xtal_ready, slow_xtal_ready, rc_ready};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			// A change is taken once stages two and three agree
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_s1[gi] <= 1'b0;
					sync_s2[gi] <= 1'b0;
					sync_s3[gi] <= 1'b0;
					pin_ok[gi]  <= 1'b0;
				end else begin
					sync_s1[gi] <= pin_raw[gi];
					sync_s2[gi] <= sync_s1[gi];
					sync_s3[gi] <= sync_s2[gi];
					if (sync_s2[gi] == sync_s3[gi]) begin
						pin_ok[gi] <= sync_s3[gi];
					end
				end
			end
		end
	endgenerate

	logic rc_ok, slow_ok, fast_ok, pwr_off;
	assign rc_ok   = pin_ok[0];
	assign slow_ok = pin_ok[1];
	assign fast_ok = pin_ok[2];
	assign pwr_off = pin_ok[3];

	// Bus decode; a write lands on the edge where pready is seen high
	logic access, wr, hit;
	assign access = psel & penable & pready;
	assign wr     = access & pwrite;

	logic t_hf_start, t_hf_stop, t_lf_start, t_lf_stop;
	logic t_cal, t_ct_start, t_ct_stop;
	// Task strobes: only a written one triggers
	assign t_hf_start = wr && paddr == OFS_HF_START && pwdata[0];
	assign t_hf_stop  = wr && paddr == OFS_HF_STOP  && pwdata[0];
	assign t_lf_start = wr && paddr == OFS_LF_START && pwdata[0];
	assign t_lf_stop  = wr && paddr == OFS_LF_STOP  && pwdata[0];
	assign t_cal      = wr && paddr == OFS_CAL      && pwdata[0];
	assign t_ct_start = wr && paddr == OFS_CT_START && pwdata[0];
	assign t_ct_stop  = wr && paddr == OFS_CT_STOP  && pwdata[0];

	// Registers and state
	lfcc_src_t              src_sel;     // Software selection
	lfcc_src_t              src_snap;    // Copy taken at start
	lfcc_lf_state_t         lf_state;
	logic                   lf_req;      // Start task seen
	logic                   hf_req;      // Fast start task seen
	logic                   hf_run;      // Fast crystal stable
	logic [EV_N-1:0]        ev_flag;
	logic [EV_N-1:0]        ev_set;
	logic [EV_N-1:0]        irq_mask;
	logic [CT_WIDTH-1:0]    ct_iv;
	logic [CT_WIDTH-1:0]    ct_count;
	logic                   ct_run;
	logic                   cal_busy;
	logic [7:0]             cal_left;
	logic [TICKW-1:0]       tick_cnt;

	// Slow-rate enable: one pulse per slow period from the divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt     <= '0;
			lowfreq_tick <= 1'b0;
		end else if (lf_state == LF_OFF) begin
			tick_cnt     <= '0;
			lowfreq_tick <= 1'b0;
		end else if (tick_cnt == TICKW'(LF_TICK_CYCLES - 1)) begin
			tick_cnt     <= '0;
			lowfreq_tick <= 1'b1;
		end else begin
			tick_cnt     <= tick_cnt + 1'b1;
			lowfreq_tick <= 1'b0;
		end
	end

	// Source selection; reset picks RC
	// Writes while running or forbidden combinations are dropped, which
	// keeps the oscillator controls in a legal pairing.
	logic      src_legal;
	lfcc_src_t src_new;
	assign src_new = '{external: pwdata[EXTERNAL_BIT],
		bypass: pwdata[BYPASS_BIT], src: pwdata[SRC_LSB+:2]};
	always_comb begin
		// Allowed table of source, external and bypass
		unique case (src_new.src)
			SRC_RC, SRC_SYNTH: src_legal = !src_new.external && !src_new.bypass;
			SRC_XTAL:          src_legal = src_new.external || !src_new.bypass;
			default:           src_legal = 1'b0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_sel <= SRC_RESET;
		end else if (wr && paddr == OFS_LF_SRC && src_legal &&
			lf_state == LF_OFF && !lf_req) begin
			src_sel <= src_new;
		end
	end

	// Snapshot and start-requested flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_snap <= SRC_RESET;
			lf_req   <= 1'b0;
		end else if (pwr_off) begin
			lf_req   <= 1'b0;
		end else if (t_lf_start) begin
			src_snap <= src_sel;
			lf_req   <= 1'b1;
		end else if (t_lf_stop && lf_state == LF_RUNNING) begin
			lf_req   <= 1'b0;
		end
	end

	// Slow clock controller
	// Stop is honoured only from the running state; earlier stops are
	// ignored.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_state <= LF_OFF;
		end else if (pwr_off) begin
			lf_state <= LF_OFF;
		end else begin
			unique case (lf_state)
				LF_OFF: begin
					if (t_lf_start) begin
						lf_state <= LF_STARTING;
					end
				end
				LF_STARTING: begin
					// Crystal case bridges on RC while it settles
					if (src_snap.src == SRC_XTAL && rc_ok) begin
						lf_state <= LF_RC_BRIDGE;
					end else if (src_snap.src == SRC_RC && rc_ok) begin
						lf_state <= LF_RUNNING;
					end else if (src_snap.src == SRC_SYNTH) begin
						lf_state <= LF_RUNNING;
					end
				end
				LF_RC_BRIDGE: begin
					if (slow_ok) begin
						lf_state <= LF_RUNNING;
					end
				end
				LF_RUNNING: begin
					if (t_lf_stop) begin
						lf_state <= LF_OFF;
					end
				end
			endcase
		end
	end

	// Oscillator controls follow the controller state
	logic lf_on;
	assign lf_on = lf_state != LF_OFF;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_enable          <= 1'b0;
			slow_xtal_enable   <= 1'b0;
			xtal_external      <= 1'b0;
			xtal_bypass        <= 1'b0;
			lowfreq_active_src <= SRC_RC;
		end else begin
			// RC also feeds the bridge while the crystal starts
			rc_enable <= lf_on && (src_snap.src == SRC_RC ||
				(src_snap.src == SRC_XTAL && lf_state != LF_RUNNING));
			slow_xtal_enable <= lf_on && src_snap.src == SRC_XTAL;
			// External swing modes on crystal pin one
			xtal_external <= lf_on && src_snap.src == SRC_XTAL &&
				src_snap.external;
			xtal_bypass   <= lf_on && src_snap.src == SRC_XTAL &&
				src_snap.external && src_snap.bypass;
			lowfreq_active_src <= (lf_state == LF_RUNNING) ? src_snap.src
				: SRC_RC;
		end
	end

	// Fast crystal start and stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hf_req <= 1'b0;
			hf_run <= 1'b0;
		end else begin
			if (pwr_off || t_hf_stop) begin
				hf_req <= 1'b0;
			end else if (t_hf_start) begin
				hf_req <= 1'b1;
			end
			hf_run <= hf_req && fast_ok;
		end
	end

	// Fast clock demand; crystal enable is registered from the request
	// so it too comes straight from a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_xtal_enable <= 1'b0;
			highfreq_request <= 1'b0;
		end else begin
			fast_xtal_enable <= hf_req;
			// Synth keeps the fast clock asked for
			highfreq_request <= hf_req || cal_busy ||
				(lf_on && src_snap.src == SRC_SYNTH);
		end
	end

	// RC trimming: runs CAL_TICKS slow periods against the fast clock.
	// It assumes the fast crystal is already running and that RC stays
	// up meanwhile; the start checks only for a running RC source, never the fast crystal.
	logic cal_done;
	assign cal_done = cal_busy && lowfreq_tick && cal_left == 8'h01;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_busy <= 1'b0;
			cal_left <= 8'h00;
		end else if (pwr_off) begin
			cal_busy <= 1'b0;
		end else if (t_cal && !cal_busy && lf_state == LF_RUNNING &&
			src_snap.src == SRC_RC) begin
			cal_busy <= 1'b1;
			cal_left <= 8'(CAL_TICKS);
		end else if (cal_done) begin
			cal_busy <= 1'b0;
		end else if (cal_busy && lowfreq_tick) begin
			cal_left <= cal_left - 8'h01;
		end
	end

	// Trim timer counts slow periods down to zero
	// Tasks closer than one slow period may be merged; software paces
	// them.
	logic ct_expire;
	assign ct_expire = ct_run && lowfreq_tick && ct_count <= CT_WIDTH'(1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ct_run   <= 1'b0;
			ct_count <= '0;
		end else if (pwr_off || t_ct_stop) begin
			ct_run   <= 1'b0;
		end else if (t_ct_start) begin
			ct_run   <= 1'b1;
			ct_count <= ct_iv;
		end else if (ct_expire) begin
			ct_run   <= 1'b0;
			ct_count <= '0;
		end else if (ct_run && lowfreq_tick) begin
			ct_count <= ct_count - 1'b1;
		end
	end

	// Interval register, retained across stops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ct_iv <= '0;
		end else if (wr && paddr == OFS_CT_IV) begin
			ct_iv <= pwdata[CT_WIDTH-1:0];
		end
	end

	// Event sources
	logic lf_started;
	assign lf_started = lf_state != LF_RUNNING && !pwr_off &&
		((lf_state == LF_STARTING && (src_snap.src == SRC_SYNTH ||
		(src_snap.src == SRC_RC && rc_ok))) ||
		(lf_state == LF_RC_BRIDGE && slow_ok));
	always_comb begin
		ev_set          = '0;
		ev_set[EV_HF]   = hf_req && fast_ok && !hf_run;
		ev_set[EV_LF]   = lf_started;
		ev_set[EV_DONE] = cal_done;
		ev_set[EV_TRIM_TIMER_EXPIRED_EVENT] = ct_expire;
	end

	// Event flags: a set in the clearing cycle wins
	generate
		for (gi = 0; gi < EV_N; gi++) begin : g_ev
			logic [11:0] ev_addr;
			assign ev_addr = OFS_EV_HF + 12'(4 * gi);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ev_flag[gi] <= 1'b0;
				end else if (ev_set[gi]) begin
					ev_flag[gi] <= 1'b1;
				end else if (wr && paddr == ev_addr && !pwdata[0]) begin
					ev_flag[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Interrupt enables and output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= '0;
			irq      <= 1'b0;
		end else begin
			if (wr && paddr == OFS_IRQ_SET) begin
				irq_mask <= irq_mask | pwdata[EV_N-1:0];
			end else if (wr && paddr == OFS_IRQ_CLR) begin
				irq_mask <= irq_mask & ~pwdata[EV_N-1:0];
			end
			irq <= |(ev_flag & irq_mask);
		end
	end

	// Read mux for the current address
	logic [31:0] rd_word;
	always_comb begin
		rd_word = RESET_WORD;
		hit     = 1'b1;
		unique case (paddr)
			OFS_HF_START, OFS_HF_STOP, OFS_LF_START, OFS_LF_STOP,
			OFS_CAL, OFS_CT_START, OFS_CT_STOP: rd_word = RESET_WORD;
			OFS_EV_HF:   rd_word[0] = ev_flag[EV_HF];
			OFS_EV_LF:   rd_word[0] = ev_flag[EV_LF];
			OFS_EV_DONE: rd_word[0] = ev_flag[EV_DONE];
			OFS_EV_TRIM_TIMER_EXPIRED_EVENT: rd_word[0] = ev_flag[EV_TRIM_TIMER_EXPIRED_EVENT];
			OFS_IRQ_SET, OFS_IRQ_CLR: rd_word[EV_N-1:0] = irq_mask;
			OFS_HF_REQ:  rd_word[0] = hf_req;
			OFS_HF_STAT: begin
				rd_word[0]         = hf_run;
				rd_word[STATE_BIT] = hf_run;
			end
			OFS_LF_REQ:  rd_word[0] = lf_req;
			OFS_LF_STAT: begin
				rd_word[SRC_LSB+:2] = lowfreq_active_src;
				rd_word[STATE_BIT]  = lf_state == LF_RUNNING;
			end
			OFS_LF_SNAP: begin
				rd_word[SRC_LSB+:2]   = src_snap.src;
				rd_word[BYPASS_BIT]   = src_snap.bypass;
				rd_word[EXTERNAL_BIT] = src_snap.external;
			end
			OFS_LF_SRC: begin
				rd_word[SRC_LSB+:2]   = src_sel.src;
				rd_word[BYPASS_BIT]   = src_sel.bypass;
				rd_word[EXTERNAL_BIT] = src_sel.external;
			end
			OFS_CT_IV:   rd_word[CT_WIDTH-1:0] = ct_iv;
			default:     hit = 1'b0;
		endcase
	end

	// APB answer: one wait state so that every output is registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RESET_WORD;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !hit || paddr[1:0] != 2'h0;
			prdata  <= (hit && !pwrite) ? rd_word : RESET_WORD;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Checks
	property p_pwr_off;
		@(posedge pclk) disable iff (!presetn)
		pwr_off |=> lf_state == LF_OFF && !cal_busy && !ct_run;
	endproperty
	a_pwr_off: assert property (p_pwr_off)
		else $error("power-off left the slow domain active");

	property p_snap;
		@(posedge pclk) disable iff (!presetn)
		t_lf_start && !pwr_off |=> src_snap == $past(src_sel) && lf_req;
	endproperty
	a_snap: assert property (p_snap)
		else $error("start did not capture the source selection");

	property p_done;
		@(posedge pclk) disable iff (!presetn)
		cal_done |=> ev_flag[EV_DONE] && !cal_busy
		##1 (irq || !$past(irq_mask[EV_DONE]));
	endproperty
	a_done: assert property (p_done)
		else $error("trim end did not raise its event");

	property p_trim_timer_expired_event;
		@(posedge pclk) disable iff (!presetn)
		ct_expire && !pwr_off && !t_ct_stop && !t_ct_start
		|=> ev_flag[EV_TRIM_TIMER_EXPIRED_EVENT] && !ct_run && ct_count == '0;
	endproperty
	a_trim_timer_expired_event: assert property (p_trim_timer_expired_event)
		else $error("timer did not expire and halt at zero");

	property p_bridge;
		@(posedge pclk) disable iff (!presetn)
		lf_state == LF_RC_BRIDGE |=> rc_enable && slow_xtal_enable;
	endproperty
	a_bridge: assert property (p_bridge)
		else $error("crystal start not bridged on RC");

	property p_synth;
		@(posedge pclk) disable iff (!presetn)
		lf_state == LF_RUNNING && src_snap.src == SRC_SYNTH
		|=> highfreq_request;
	endproperty
	a_synth: assert property (p_synth)
		else $error("synthesized source dropped the fast clock");

	property p_stop;
		@(posedge pclk) disable iff (!presetn)
		t_lf_stop && lf_state == LF_RUNNING && !pwr_off
		|=> lf_state == LF_OFF ##1 !rc_enable && !slow_xtal_enable;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop task did not halt the slow clock");

	property p_src_legal;
		@(posedge pclk) disable iff (!presetn)
		!(src_sel.src != SRC_XTAL && (src_sel.external || src_sel.bypass))
		&& !(src_sel.bypass && !src_sel.external) && src_sel.src != 2'h3;
	endproperty
	a_src_legal: assert property (p_src_legal)
		else $error("forbidden source combination stored");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		$rose(ev_flag[EV_LF]) && irq_mask[EV_LF] |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("enabled event did not raise the interrupt");

endmodule : lfcc_lowfreq_clock_control

`default_nettype wire

// ---- tb/lfcc_lowfreq_clock_control_tb.sv ----
// Self-checking bench for the low-frequency clock controller.
// Assumes the APB slave answers after one wait state; oscillator levels
// are driven here in place of the analog cells.
`timescale 1ns/1ps
`default_nettype none
module lfcc_lowfreq_clock_control_tb;
	import lfcc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, irq;
	logic        rc_ready, slow_xtal_ready, fast_xtal_ready, system_off;
	logic        rc_enable, slow_xtal_enable, xtal_external, xtal_bypass;
	logic        fast_xtal_enable, highfreq_request, lowfreq_tick;
	logic [1:0]  lowfreq_active_src;
	logic [31:0] rd;          // Last read data
	logic        er;          // Last slave error
	int          fail_count;  // Mismatches
	int          check_count; // Comparisons

	// Short trim run keeps the simulation brief
	lfcc_lowfreq_clock_control #(.CAL_TICKS(2)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rc_ready(rc_ready),
		.slow_xtal_ready(slow_xtal_ready),
		.fast_xtal_ready(fast_xtal_ready), .system_off(system_off),
		.rc_enable(rc_enable), .slow_xtal_enable(slow_xtal_enable),
		.xtal_external(xtal_external), .xtal_bypass(xtal_bypass),
		.fast_xtal_enable(fast_xtal_enable),
		.highfreq_request(highfreq_request),
		.lowfreq_active_src(lowfreq_active_src),
		.lowfreq_tick(lowfreq_tick), .irq(irq));

	// 100 MHz clock
	always #5 pclk = ~pclk;

	// Verdict and end of run, shared by the timeout path
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop

	// One compare for every 32-bit result
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// APB transfer: request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("BAD pready expected 1 seen 0");
			report_and_stop();
		end
		rd      = prdata;
		er      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Bounded poll of an event flag; a timeout ends the run
	task automatic poll(input logic [11:0] a, input int lim);
		int n;
		n = 0;
		apb(1'b0, a, '0);
		while (rd[0] !== 1'b1 && n < lim) begin
			apb(1'b0, a, '0);
			n++;
		end
		if (rd[0] !== 1'b1) begin
			fail_count++;
			$display("BAD poll %h expected 1 seen 0", a);
			report_and_stop();
		end
	endtask : poll

	// RC start, trim, timer, interrupt, dropped source write, stop
	task automatic rc_and_trim();
		apb(1'b0, OFS_LF_SRC, '0);
		chk("src_reset", 32'h0000_0000, rd);
		apb(1'b0, 12'h200, '0);
		chk("unmapped_err", 32'h0000_0001, {31'h0, er});
		apb(1'b1, OFS_LF_START, 32'h0000_0001);
		poll(OFS_EV_LF, 50);
		apb(1'b0, OFS_LF_REQ, '0);
		chk("lf_requested", 32'h0000_0001, rd);
		apb(1'b0, OFS_LF_STAT, '0);
		chk("lf_stat_rc", 32'h0001_0000, rd);
		apb(1'b1, OFS_HF_START, 32'h0000_0001);
		poll(OFS_EV_HF, 50);
		chk("fast_en", 32'h0000_0001, {31'h0, fast_xtal_enable});
		apb(1'b1, OFS_CAL, 32'h0000_0001);
		chk("hf_request", 32'h0000_0001, {31'h0, highfreq_request});
		poll(OFS_EV_DONE, 3000);
		apb(1'b1, OFS_CT_IV, 32'h0000_0002);
		apb(1'b1, OFS_CT_START, 32'h0000_0001);
		apb(1'b0, OFS_EV_TRIM_TIMER_EXPIRED_EVENT, '0);
		chk("trim_timer_expired_event_early", 32'h0000_0000, rd);
		poll(OFS_EV_TRIM_TIMER_EXPIRED_EVENT, 3000);
		apb(1'b1, OFS_IRQ_SET, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk("irq_on", 32'h0000_0001, {31'h0, irq});
		apb(1'b1, OFS_IRQ_CLR, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		chk("irq_off", 32'h0000_0000, {31'h0, irq});
		apb(1'b1, OFS_EV_LF, 32'h0000_0000);
		apb(1'b0, OFS_EV_LF, '0);
		chk("ev_cleared", 32'h0000_0000, rd);
		apb(1'b1, OFS_LF_SRC, 32'h0000_0002);
		apb(1'b0, OFS_LF_SRC, '0);
		chk("src_locked", 32'h0000_0000, rd);
		apb(1'b1, OFS_LF_STOP, 32'h0000_0001);
		repeat (8) @(posedge pclk);
		apb(1'b0, OFS_LF_STAT, '0);
		chk("lf_stopped", 32'h0000_0000, rd);
	endtask : rc_and_trim

	// Forbidden RC-with-bypass combination dropped, then crystal start bridged on RC
	task automatic crystal_start();
		apb(1'b1, OFS_LF_SRC, 32'h0001_0000);
		apb(1'b0, OFS_LF_SRC, '0);
		chk("src_forbidden", 32'h0000_0000, rd);
		apb(1'b1, OFS_LF_SRC, 32'h0002_0001);
		apb(1'b1, OFS_LF_START, 32'h0000_0001);
		repeat (10) @(posedge pclk);
		chk("bridge_src", 32'h0000_0000, {30'h0, lowfreq_active_src});
		chk("xtal_ext", 32'h0000_0001, {31'h0, xtal_external});
		chk("xtal_byp", 32'h0000_0000, {31'h0, xtal_bypass});
		apb(1'b0, OFS_EV_LF, '0);
		chk("no_early_ev", 32'h0000_0000, rd);
		slow_xtal_ready <= 1'b1;
		poll(OFS_EV_LF, 50);
		chk("xtal_src", {30'h0, SRC_XTAL}, {30'h0, lowfreq_active_src});
		apb(1'b0, OFS_LF_SNAP, '0);
		chk("snapshot", 32'h0002_0001, rd);
		system_off <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("off_xtal", 32'h0000_0000, {31'h0, slow_xtal_enable});
		chk("off_rc", 32'h0000_0000, {31'h0, rc_enable});
	endtask : crystal_start

	// Mid-run reset, synthesized source, tick rate, fast crystal stop
	task automatic synth_run();
		int n;
		system_off <= 1'b0;
		presetn    <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFS_LF_SRC, '0);
		chk("src_after_rst", 32'h0000_0000, rd);
		apb(1'b1, OFS_IRQ_SET, 32'h0000_0002);
		apb(1'b1, OFS_LF_SRC, {30'h0, SRC_SYNTH});
		apb(1'b1, OFS_LF_START, 32'h0000_0001);
		poll(OFS_EV_LF, 50);
		chk("irq_synth", 32'h0000_0001, {31'h0, irq});
		chk("synth_hf_req", 32'h0000_0001, {31'h0, highfreq_request});
		apb(1'b0, OFS_LF_STAT, '0);
		chk("lf_stat_synth", 32'h0001_0002, rd);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (lowfreq_tick !== 1'b1 && n < 8000);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (lowfreq_tick !== 1'b1 && n < 8000);
		chk("tick_period", LF_TICK_CYCLES, n);
		if (n >= 8000) begin
			report_and_stop();
		end
		apb(1'b1, OFS_HF_START, 32'h0000_0001);
		apb(1'b1, OFS_HF_STOP, 32'h0000_0001);
		apb(1'b0, OFS_HF_REQ, '0);
		chk("hf_stopped", 32'h0000_0000, rd);
		apb(1'b1, OFS_LF_STOP, 32'h0000_0001);
		repeat (4) @(posedge pclk);
		chk("synth_hf_off", 32'h0000_0000, {31'h0, highfreq_request});
	endtask : synth_run

	// Main sequence
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = '0; pwdata = '0; rc_ready = 1; slow_xtal_ready = 0;
		fast_xtal_ready = 1; system_off = 0;
		fail_count = 0; check_count = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rc_and_trim();
		crystal_start();
		synth_run();
		report_and_stop();
	end
endmodule : lfcc_lowfreq_clock_control_tb
`default_nettype wire
